// file: shared/idc_pkg.sv
// Constants and carrier types for the transmit datapath control block
package idc_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] IDC_ADDR_DATAPATH = 8'h1b;
  localparam logic [7:0] IDC_ADDR_FIRST    = 8'h1c;
  localparam logic [7:0] IDC_ADDR_SECOND   = 8'h1d;

  // ************************************************************
  // Reset values and writable-bit masks
  // ************************************************************
  localparam logic [7:0] IDC_RESET_DATAPATH = 8'he4;
  localparam logic [7:0] IDC_RESET_FIRST    = 8'h00;
  localparam logic [7:0] IDC_RESET_SECOND   = 8'h00;
  // Bit 4 of the datapath register is reserved and reads as zero
  localparam logic [7:0] IDC_MASK_DATAPATH  = 8'hef;
  localparam logic [7:0] IDC_MASK_FIRST     = 8'h07;
  localparam logic [7:0] IDC_MASK_SECOND    = 8'h7f;
  localparam logic [7:0] IDC_READ_UNMAPPED  = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int IDC_BIT_SKIP_PREMOD   = 7;
  localparam int IDC_BIT_SKIP_SINC     = 6;
  localparam int IDC_BIT_SKIP_NCO      = 5;
  localparam int IDC_BIT_NCO_HALF      = 3;
  localparam int IDC_BIT_SKIP_PHASE_DC = 2;
  localparam int IDC_BIT_LOWER_SIDE    = 1;
  localparam int IDC_BIT_MIRROR_I      = 0;
  localparam int IDC_BIT_SKIP_STAGE    = 0;
  localparam int IDC_FIRST_MODE_LSB    = 1;
  localparam int IDC_FIRST_MODE_MSB    = 2;
  localparam int IDC_SECOND_MODE_LSB   = 1;
  localparam int IDC_SECOND_MODE_MSB   = 6;
  localparam int IDC_SECOND_SHIFT_LSB  = 4;
  // Fraction bits of the oscillator samples, which are Q1.15
  localparam int IDC_NCO_FRAC          = 15;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } idc_iq_t;

  typedef struct packed {
    logic [7:0]  datapath_config;
    logic [7:0]  first_interp_stage_config;
    logic [7:0]  second_interp_stage_config;
    logic [7:0]  rdata;
    logic        premod_phase;
    idc_iq_t     stage_a;
    logic        valid_a;
    idc_iq_t     stage_b;
    logic        valid_b;
    logic        skip_sinc;
    logic        skip_phase_dc;
    logic        q_clock_enable;
    logic [1:0]  first_halfband_mode;
    logic        first_modulate;
    logic        skip_first_stage;
    logic [5:0]  second_halfband_mode;
    logic [2:0]  second_shift;
    logic        second_modulate;
    logic        skip_second_stage;
  } idc_state_t;

endpackage : idc_pkg

// file: rtl/idc_datapath_control.sv
// Transmit datapath control: registers, routing, premodulation, modulator
// What this block does
// R1: Bit 7 set skips fs/2 premodulation
// R2: Bit 6 set skips inverse sinc filter
// R3: Bit 5 set skips oscillator complex modulation
// R4: Bit 3 halves oscillator input to modulator
// R5: Bit 2 set skips phase and dc stages
// R6: Bit 1 picks lower, inverted image
// R7: Bit 0 drops Q, gates Q clocks, mirrors I
// R8: First stage mode codes, upper code modulates
// R9: First stage register bit 0 skips filter
// R10: Second stage mode codes, quarter-rate passband steps
// R11: Second stage register bit 0 skips filter
module idc_datapath_control
  import idc_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  input  wire logic               i_reg_write,
  input  wire logic               i_reg_read,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  output logic      [7:0]         o_reg_rdata,
  input  wire logic               i_sample_valid,
  input  wire logic signed [15:0] i_i_data,
  input  wire logic signed [15:0] i_q_data,
  input  wire logic signed [15:0] i_nco_cos,
  input  wire logic signed [15:0] i_nco_sin,
  output logic                    o_sample_valid,
  output logic signed [15:0]      o_i_data,
  output logic signed [15:0]      o_q_data,
  output logic                    o_skip_sinc,
  output logic                    o_skip_phase_dc,
  output logic                    o_q_clock_enable,
  output logic      [1:0]         o_first_halfband_mode,
  output logic                    o_first_modulate,
  output logic                    o_skip_first_stage,
  output logic      [5:0]         o_second_halfband_mode,
  output logic      [2:0]         o_second_shift,
  output logic                    o_second_modulate,
  output logic                    o_skip_second_stage
);

  // ************************************************************
  // Arithmetic helpers
  // ************************************************************

  // Clamp a wide signed value into 16 bits
  function automatic logic signed [15:0] idc_sat(
    input logic signed [32:0] value
  );
    logic signed [32:0] hi;
    logic signed [32:0] lo;
    hi = 33'sh7fff;
    lo = -33'sh8000;
    if (value > hi) begin
      idc_sat = 16'sh7fff;
    end else if (value < lo) begin
      idc_sat = -16'sh8000;
    end else begin
      idc_sat = value[15:0];
    end
  endfunction : idc_sat

  // Negation that cannot wrap the most negative code
  function automatic logic signed [15:0] idc_neg(
    input logic signed [15:0] value
  );
    logic signed [32:0] wide;
    wide = 33'(value);
    idc_neg = idc_sat(-wide);
  endfunction : idc_neg

  // a*b plus or minus c*d, rescaled by the oscillator fraction bits
  function automatic logic signed [15:0] idc_cmac(
    input logic signed [15:0] a,
    input logic signed [15:0] b,
    input logic signed [15:0] c,
    input logic signed [15:0] d,
    input logic               subtract
  );
    logic signed [32:0] p1;
    logic signed [32:0] p2;
    logic signed [32:0] acc;
    p1  = 33'(a) * 33'(b);
    p2  = 33'(c) * 33'(d);
    acc = subtract ? (p1 - p2) : (p1 + p2);
    idc_cmac = idc_sat(acc >>> IDC_NCO_FRAC);
  endfunction : idc_cmac

  // Optional half gain on a carrier sample; the shift floors odd codes
  function automatic logic signed [15:0] idc_scale(
    input logic signed [15:0] value,
    input logic               half
  );
    if (half) begin
      idc_scale = value >>> 1;
    end else begin
      idc_scale = value;
    end
  endfunction : idc_scale

  // fs/2 premodulation of one rail: negate on odd phase unless skipped
  function automatic logic signed [15:0] idc_premod(
    input logic signed [15:0] value,
    input logic               negate
  );
    if (negate) begin
      idc_premod = idc_neg(value);
    end else begin
      idc_premod = value;
    end
  endfunction : idc_premod

  // One-hot register select: bit 0 datapath, bit 1 first, bit 2 second
  function automatic logic [2:0] idc_reg_sel(
    input logic [7:0] addr
  );
    if (addr == IDC_ADDR_DATAPATH) begin
      idc_reg_sel = 3'h1;
    end else if (addr == IDC_ADDR_FIRST) begin
      idc_reg_sel = 3'h2;
    end else if (addr == IDC_ADDR_SECOND) begin
      idc_reg_sel = 3'h4;
    end else begin
      idc_reg_sel = 3'h0;
    end
  endfunction : idc_reg_sel

  // ************************************************************
  // State
  // ************************************************************
  idc_state_t state;
  idc_state_t next_state;

  logic               skip_premod;
  logic               skip_nco;
  logic               nco_half;
  logic               lower_side;
  logic               mirror_i;
  logic signed [15:0] route_i;
  logic signed [15:0] route_q;
  logic signed [15:0] cos_g;
  logic signed [15:0] sin_g;
  logic [7:0]         wdata_dp;
  logic [7:0]         wdata_first;
  logic [7:0]         wdata_second;
  logic [2:0]         reg_sel;
  logic               premod_negate;

  // Control bits decoded straight from the stored configuration
  assign skip_premod = state.datapath_config[IDC_BIT_SKIP_PREMOD];
  assign skip_nco    = state.datapath_config[IDC_BIT_SKIP_NCO];
  assign nco_half    = state.datapath_config[IDC_BIT_NCO_HALF];
  assign lower_side  = state.datapath_config[IDC_BIT_LOWER_SIDE];
  assign mirror_i    = state.datapath_config[IDC_BIT_MIRROR_I];

  // Masked write data, so reserved bits never store a one
  assign wdata_dp     = i_reg_wdata & IDC_MASK_DATAPATH;
  assign wdata_first  = i_reg_wdata & IDC_MASK_FIRST;
  assign wdata_second = i_reg_wdata & IDC_MASK_SECOND;

  // One decode shared by writes and reads, so the map cannot diverge
  assign reg_sel = idc_reg_sel(i_reg_addr);

  // Odd-phase samples flip sign only while premodulation is in use
  assign premod_negate = ~skip_premod & state.premod_phase; // R1

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_state = state;
    route_i    = i_i_data;
    route_q    = i_q_data;
    cos_g      = i_nco_cos;
    sin_g      = i_nco_sin;

    // Register writes; the address decode is a plain priority chain
    if (i_reg_write) begin
      if (reg_sel[0]) begin
        next_state.datapath_config = wdata_dp;
      end else if (reg_sel[1]) begin
        next_state.first_interp_stage_config = wdata_first;
      end else if (reg_sel[2]) begin
        next_state.second_interp_stage_config = wdata_second;
      end
    end

    // Read data is held until the next read
    if (i_reg_read) begin
      if (reg_sel[0]) begin
        next_state.rdata = state.datapath_config;
      end else if (reg_sel[1]) begin
        next_state.rdata = state.first_interp_stage_config;
      end else if (reg_sel[2]) begin
        next_state.rdata = state.second_interp_stage_config;
      end else begin
        next_state.rdata = IDC_READ_UNMAPPED;
      end
    end

    // Control outputs for stages that live outside this block
    next_state.skip_sinc =
      state.datapath_config[IDC_BIT_SKIP_SINC]; // R2
    next_state.skip_phase_dc =
      state.datapath_config[IDC_BIT_SKIP_PHASE_DC]; // R5
    // Q path clocks stop while I is mirrored to both converters
    next_state.q_clock_enable = ~mirror_i; // R7

    // First half-band stage: upper mode bit means modulate first
    next_state.first_halfband_mode = state.first_interp_stage_config
      [IDC_FIRST_MODE_MSB:IDC_FIRST_MODE_LSB]; // R8
    next_state.first_modulate =
      state.first_interp_stage_config[IDC_FIRST_MODE_MSB]; // R8
    next_state.skip_first_stage =
      state.first_interp_stage_config[IDC_BIT_SKIP_STAGE]; // R9

    // Second stage: upper three code bits give the quarter-rate step
    next_state.second_halfband_mode = state.second_interp_stage_config
      [IDC_SECOND_MODE_MSB:IDC_SECOND_MODE_LSB]; // R10
    next_state.second_shift = state.second_interp_stage_config
      [IDC_SECOND_MODE_MSB:IDC_SECOND_SHIFT_LSB]; // R10
    next_state.second_modulate =
      state.second_interp_stage_config[IDC_SECOND_MODE_MSB]; // R10
    next_state.skip_second_stage =
      state.second_interp_stage_config[IDC_BIT_SKIP_STAGE]; // R11

    // Stage A: channel routing, then fs/2 premodulation
    if (mirror_i) begin
      route_q = i_i_data; // R7
    end
    next_state.valid_a = i_sample_valid;
    if (i_sample_valid) begin
      // Alternate samples are negated; the phase runs only on data
      next_state.premod_phase = ~state.premod_phase;
      next_state.stage_a.i = idc_premod(route_i, premod_negate); // R1
      next_state.stage_a.q = idc_premod(route_q, premod_negate); // R1
    end

    // Halving the carrier trades 6 dB of level for saturation only at the full-scale corners
    cos_g = idc_scale(i_nco_cos, nco_half); // R4
    sin_g = idc_scale(i_nco_sin, nco_half); // R4

    // Stage B: complex modulator or straight pass
    next_state.valid_b = state.valid_a;
    if (state.valid_a) begin
      if (skip_nco) begin
        next_state.stage_b = state.stage_a; // R3
      end else if (!lower_side) begin
        // Upper image: (I + jQ)(cos + j sin)
        next_state.stage_b.i = idc_cmac(state.stage_a.i, cos_g,
                                        state.stage_a.q, sin_g,
                                        1'b1); // R6
        next_state.stage_b.q = idc_cmac(state.stage_a.i, sin_g,
                                        state.stage_a.q, cos_g,
                                        1'b0); // R6
      end else begin
        // Lower image: conjugate carrier, spectrum inverted
        next_state.stage_b.i = idc_cmac(state.stage_a.i, cos_g,
                                        state.stage_a.q, sin_g,
                                        1'b0); // R6
        next_state.stage_b.q = idc_cmac(state.stage_a.q, cos_g,
                                        state.stage_a.i, sin_g,
                                        1'b1); // R6
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state                            <= '0;
      state.datapath_config            <= IDC_RESET_DATAPATH;
      state.first_interp_stage_config  <= IDC_RESET_FIRST;
      state.second_interp_stage_config <= IDC_RESET_SECOND;
      state.skip_sinc                  <= 1'b1;
      state.skip_phase_dc              <= 1'b1;
      state.q_clock_enable             <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs, all straight from the state register
  // ************************************************************
  assign o_reg_rdata            = state.rdata;
  assign o_sample_valid         = state.valid_b;
  assign o_i_data               = state.stage_b.i;
  assign o_q_data               = state.stage_b.q;
  assign o_skip_sinc            = state.skip_sinc;
  assign o_skip_phase_dc        = state.skip_phase_dc;
  assign o_q_clock_enable       = state.q_clock_enable;
  assign o_first_halfband_mode  = state.first_halfband_mode;
  assign o_first_modulate       = state.first_modulate;
  assign o_skip_first_stage     = state.skip_first_stage;
  assign o_second_halfband_mode = state.second_halfband_mode;
  assign o_second_shift         = state.second_shift;
  assign o_second_modulate      = state.second_modulate;
  assign o_skip_second_stage    = state.skip_second_stage;

endmodule : idc_datapath_control

// file: dv/idc_assertions.sv
// Port-level checks for the transmit datapath control block
module idc_chk
  import idc_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_reset_n,
  input  wire logic               i_reg_write,
  input  wire logic               i_reg_read,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  input  wire logic [7:0]         o_reg_rdata,
  input  wire logic               i_sample_valid,
  input  wire logic               o_sample_valid,
  input  wire logic signed [15:0] o_i_data,
  input  wire logic signed [15:0] o_q_data,
  input  wire logic               o_skip_sinc,
  input  wire logic               o_skip_phase_dc,
  input  wire logic               o_q_clock_enable,
  input  wire logic [1:0]         o_first_halfband_mode,
  input  wire logic               o_first_modulate,
  input  wire logic               o_skip_first_stage,
  input  wire logic [5:0]         o_second_halfband_mode,
  input  wire logic [2:0]         o_second_shift,
  input  wire logic               o_second_modulate,
  input  wire logic               o_skip_second_stage
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Write strobes per register, decoded lag is two edges
  logic wr_dp, wr_one, wr_two, rd_map;
  assign wr_dp  = i_reg_write && i_reg_addr == IDC_ADDR_DATAPATH;
  assign wr_one = i_reg_write && i_reg_addr == IDC_ADDR_FIRST;
  assign wr_two = i_reg_write && i_reg_addr == IDC_ADDR_SECOND;
  assign rd_map = i_reg_addr inside {[8'h1b:8'h1d]};
  chk_valid_delay: assert property (i_sample_valid |-> ##2 o_sample_valid)
    else $error("output valid missing two cycles after input");
  chk_valid_quiet: assert property (!i_sample_valid |-> ##2 !o_sample_valid)
    else $error("output valid without an input sample");
  chk_data_hold: assert property (!o_sample_valid |-> $stable({o_i_data,
    o_q_data})) else $error("output data moved without valid");
  chk_dp_decode: assert property (wr_dp |-> ##2
    o_skip_sinc == $past(i_reg_wdata[6], 2) &&
    o_skip_phase_dc == $past(i_reg_wdata[2], 2) &&
    o_q_clock_enable == !$past(i_reg_wdata[0], 2))
    else $error("datapath flags do not follow write");
  chk_first_decode: assert property (wr_one |-> ##2
    o_first_halfband_mode == $past(i_reg_wdata[2:1], 2) &&
    o_skip_first_stage == $past(i_reg_wdata[0], 2))
    else $error("first stage controls do not follow write");
  chk_second_decode: assert property (wr_two |-> ##2
    o_second_halfband_mode == $past(i_reg_wdata[6:1], 2) &&
    o_skip_second_stage == $past(i_reg_wdata[0], 2))
    else $error("second stage controls do not follow write");
  chk_mode_split: assert property (o_first_modulate ==
    o_first_halfband_mode[1] && o_second_modulate ==
    o_second_halfband_mode[5] && o_second_shift ==
    o_second_halfband_mode[5:3]) else $error("modulate or shift wrong");
  chk_unmapped_zero: assert property (i_reg_read && !rd_map |=>
    o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!i_reg_read |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  // Main scenarios reached
  cover property (i_sample_valid ##2 o_sample_valid);
  cover property (wr_dp ##2 !o_q_clock_enable);
  cover property (i_reg_read && !rd_map);
endmodule : idc_chk

bind idc_datapath_control idc_chk i_chk (.*);

// file: dv/testbench.sv
// Self-checking bench for the transmit datapath control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import idc_pkg::*;
  logic clk, rst_n, wr, rd, sv, ov, sinc, phdc, qen, m1, k1, m2, k2, ph;
  logic [7:0] addr, wdata, rdata, dp, f1, f2;
  logic signed [15:0] di, dq, nc, ns, oi, oq;
  logic [1:0] h1;
  logic [5:0] h2;
  logic [2:0] sh;
  logic [31:0] seed = 32'h54;
  int miscompares = 0;
  int comparisons = 0;

  idc_datapath_control i_dut (
    .i_clock(clk), .i_reset_n(rst_n), .i_reg_write(wr), .i_reg_read(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_sample_valid(sv), .i_i_data(di), .i_q_data(dq), .i_nco_cos(nc),
    .i_nco_sin(ns), .o_sample_valid(ov), .o_i_data(oi), .o_q_data(oq),
    .o_skip_sinc(sinc), .o_skip_phase_dc(phdc), .o_q_clock_enable(qen),
    .o_first_halfband_mode(h1), .o_first_modulate(m1),
    .o_skip_first_stage(k1), .o_second_halfband_mode(h2),
    .o_second_shift(sh), .o_second_modulate(m2), .o_skip_second_stage(k2));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ************************************************************
  // Reference functions
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic signed [15:0] sat(logic signed [33:0] v);
    if (v > 34'sh7fff) return 16'sh7fff;
    if (v < -34'sh8000) return 16'sh8000;
    return v[15:0];
  endfunction : sat

  // Negating full scale would wrap, so it clips
  function automatic logic signed [15:0] neg(logic signed [15:0] x);
    return (x == 16'sh8000) ? 16'sh7fff : -x;
  endfunction : neg

  function automatic logic [31:0] model(logic signed [15:0] i, q, c, s,
                                        logic p);
    logic signed [33:0] a, b;
    if (dp[0]) q = i;
    if (p && !dp[7]) begin
      i = neg(i);
      q = neg(q);
    end
    if (dp[5]) return {i, q};
    if (dp[3]) begin
      c = c >>> 1;
      s = s >>> 1;
    end
    a = dp[1] ? i * c + q * s : i * c - q * s;
    b = dp[1] ? q * c - i * s : i * s + q * c;
    return {sat(a >>> 15), sat(b >>> 15)};
  endfunction : model

  function automatic logic [7:0] exp_reg(logic [7:0] a);
    case (a)
      IDC_ADDR_DATAPATH: return dp;
      IDC_ADDR_FIRST:    return f1;
      IDC_ADDR_SECOND:   return f2;
      default:           return 8'h00;
    endcase
  endfunction : exp_reg

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Idle cycle after each strobe keeps drivers from double assignment
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    if (a == IDC_ADDR_DATAPATH) dp = d & IDC_MASK_DATAPATH;
    if (a == IDC_ADDR_FIRST) f1 = d & IDC_MASK_FIRST;
    if (a == IDC_ADDR_SECOND) f2 = d & IDC_MASK_SECOND;
    @(posedge clk);
    #1;
  endtask : wr_reg

  task automatic rd_all();
    for (int a = 8'h1a; a <= 8'h1e; a++) begin
      rd = 1'b1;
      addr = a[7:0];
      @(posedge clk);
      #1;
      rd = 1'b0;
      check("rdata", rdata, exp_reg(a[7:0]));
      @(posedge clk);
      #1;
    end
  endtask : rd_all

  task automatic chk_dec();
    check("skip_sinc", sinc, dp[6]);
    check("skip_phase_dc", phdc, dp[2]);
    check("q_clock_enable", qen, !dp[0]);
    check("first_mode", {m1, h1, k1}, {f1[2], f1[2:1], f1[0]});
    check("second_mode", {m2, sh, h2}, {f2[6], f2[6:4], f2[6:1]});
    check("skip_second", k2, f2[0]);
  endtask : chk_dec

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    dp = IDC_RESET_DATAPATH;
    f1 = IDC_RESET_FIRST;
    f2 = IDC_RESET_SECOND;
    ph = 1'b0;
    chk_dec();
    rd_all();
  endtask : do_reset

  // Output of a sample is checked two cycles after it is driven
  task automatic run(int n);
    logic signed [15:0] pi, pq;
    logic pv, pp, ev;
    logic [31:0] e, r;
    pv = 1'b0;
    ev = 1'b0;
    pp = 1'b0;
    {pi, pq, e} = '0;
    for (int k = 0; k < n + 2; k++) begin
      @(posedge clk);
      #1;
      check("o_valid", ov, ev);
      if (ev) check("o_data", {oi, oq}, e);
      r = rnd();
      nc = (r[2:0] == 3'h0) ? 16'sh8000 : r[15:0];
      ns = r[31:16];
      ev = pv;
      e = model(pi, pq, nc, ns, pp);
      r = rnd();
      pv = (k < n) && (r[1:0] != 2'h0);
      pi = (r[5:2] == 4'h0) ? 16'sh8000 : r[15:0];
      pq = r[31:16];
      pp = ph;
      if (pv) ph = ~ph;
      sv = pv;
      di = pi;
      dq = pq;
    end
  endtask : run

  // Main sequence: reset, then configurations with traffic
  initial begin
    {rst_n, wr, rd, sv, addr, wdata, di, dq, nc, ns, ph, dp, f1, f2} = '0;
    do_reset();
    run(20);
    for (int k = 0; k < 12; k++) begin
      logic [31:0] r;
      r = rnd();
      wr_reg(IDC_ADDR_DATAPATH, r[15:8]);
      wr_reg(IDC_ADDR_FIRST, {r[23:19], k[1:0], r[24]});
      wr_reg(IDC_ADDR_SECOND, {r[25], k[2:0], k[2:0], r[26]});
      // Unmapped write last, so any alias into a register shows up
      wr_reg(r[0] ? 8'h1a : 8'h1e, ~r[15:8]);
      chk_dec();
      rd_all();
      run(24);
    end
    do_reset();
    run(8);
    end_of_test();
  end

  // Watchdog far beyond the roughly 600 cycles the run needs
  initial begin
    #(40 * 20000);
    miscompares++;
    end_of_test();
  end
endmodule : testbench
